// *** common/sdb_pkg.sv ***
// Constants, register map and types of the shift, digit, BCD and bit unit
package sdb_pkg;
  // ==========================================================
  // Register byte addresses on the bus
  localparam logic [7:0] SDB_CTRL_OFS = 8'h00;
  localparam logic [7:0] SDB_DATA_OFS = 8'h04;
  localparam logic [7:0] SDB_ACC_OFS = 8'h08;
  localparam logic [7:0] SDB_MEM_OFS = 8'h0C;
  localparam logic [7:0] SDB_PSW_OFS = 8'h10;
  localparam logic [7:0] SDB_SADDR_OFS = 8'h14;
  localparam logic [7:0] SDB_SFR_OFS = 8'h18;
  localparam logic [7:0] SDB_XREG_OFS = 8'h1C;
  // ==========================================================
  // Command word fields
  localparam int SDB_OP_LSB = 0;
  localparam int SDB_CNT_LSB = 4;
  localparam int SDB_BIT_LSB = 8;
  localparam int SDB_NEG_BIT = 11;
  localparam int SDB_SEL_LSB = 12;
  localparam int SDB_DIR_BIT = 15;
  localparam int SDB_BUSY_BIT = 31;
  // ==========================================================
  // Status word flag positions
  localparam int SDB_PSW_Z = 6;
  localparam int SDB_PSW_AC = 4;
  localparam int SDB_PSW_CY = 0;
  // ==========================================================
  // Values after reset
  localparam logic [15:0] SDB_CTRL_RST = 16'h0000;
  localparam logic [15:0] SDB_DATA_RST = 16'h0000;
  localparam logic [7:0] SDB_BYTE_RST = 8'h00;
  localparam logic [2:0] SDB_CNT_RST = 3'h0;
  // ==========================================================
  // Decimal correction terms and digit limit
  localparam logic [7:0] SDB_FIX_LO = 8'h06;
  localparam logic [7:0] SDB_FIX_HI = 8'h60;
  localparam logic [7:0] SDB_FIX_BOTH = 8'h66;
  localparam logic [3:0] SDB_DIGIT_MAX = 4'h9;
  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    SDB_OP_NONE = 4'h0,
    SDB_OP_SHR = 4'h1,
    SDB_OP_SHL = 4'h2,
    SDB_OP_WORD_LOGICAL_RIGHT_SHIFT = 4'h3,
    SDB_OP_WORD_LOGICAL_LEFT_SHIFT = 4'h4,
    SDB_OP_NIBBLE_ROTATE_RIGHT = 4'h5,
    SDB_OP_NIBBLE_ROTATE_LEFT = 4'h6,
    SDB_OP_ADJA = 4'h7,
    SDB_OP_ADJS = 4'h8,
    SDB_OP_MOVB = 4'h9,
    SDB_OP_ANDB = 4'hA
  } sdb_op_t;
  // Bit operand sources
  typedef enum logic [2:0] {
    SDB_SEL_SADDR = 3'h0,
    SDB_SEL_SFR = 3'h1,
    SDB_SEL_ACC = 3'h2,
    SDB_SEL_X = 3'h3,
    SDB_SEL_PSW = 3'h4
  } sdb_sel_t;
  // Sequencer states, Gray coded
  typedef enum logic [1:0] {
    SDB_IDLE = 2'b00,
    SDB_STEP = 2'b01
  } sdb_state_t;
endpackage : sdb_pkg

// *** logic/sdb_bcd_unit.sv ***
// Decimal adjustment and nibble rotation, purely combinational
`timescale 1ns/1ps
module sdb_bcd_unit import sdb_pkg::*; (
  input wire logic [7:0] accIn,
  input wire logic [7:0] memIn,
  input wire logic cyIn,
  input wire logic acIn,
  input wire logic subSel,
  output logic [7:0] adjAcc,
  output logic adjCy,
  output logic adjAc,
  output logic [7:0] rorAcc,
  output logic [7:0] rorMem,
  output logic [7:0] rolAcc,
  output logic [7:0] rolMem
);
  // ==========================================================
  // Digit rotations, upper accumulator nibble kept
  assign rorAcc = {accIn[7:4], memIn[3:0]};
  assign rorMem = {accIn[3:0], memIn[7:4]};
  assign rolAcc = {accIn[7:4], memIn[7:4]};
  assign rolMem = {memIn[3:0], accIn[3:0]};
  // ==========================================================
  // Decimal correction table
  always_comb begin
    logic [3:0] lo;
    logic [3:0] hi;
    lo = accIn[3:0];
    hi = accIn[7:4];
    adjAcc = accIn;
    adjCy = 1'b0;
    adjAc = 1'b0;
    if (subSel) begin
      // Borrow path: flags select the term
      if (!acIn && cyIn) begin
        adjAcc = accIn - SDB_FIX_HI;
        adjCy = 1'b1;
      end else if (acIn && !cyIn) begin
        adjAcc = accIn - SDB_FIX_LO;
        adjAc = 1'b1;
      end else if (acIn) begin
        adjAcc = accIn - SDB_FIX_BOTH;
        adjCy = 1'b1;
        adjAc = 1'b1;
      end
    end else if (!acIn && lo <= SDB_DIGIT_MAX) begin
      // Low digit valid
      if (hi > SDB_DIGIT_MAX || cyIn) begin
        adjAcc = accIn + SDB_FIX_HI;
        adjCy = 1'b1;
      end
    end else if (!acIn) begin
      // Low digit overflowed; strict limit on high digit
      if (hi < SDB_DIGIT_MAX && !cyIn) begin
        adjAcc = accIn + SDB_FIX_LO;
        adjAc = 1'b1;
      end else begin
        adjAcc = accIn + SDB_FIX_BOTH;
        adjCy = 1'b1;
        adjAc = 1'b1;
      end
    end else if (hi <= SDB_DIGIT_MAX && !cyIn) begin
      adjAcc = accIn + SDB_FIX_LO;
      adjAc = 1'b1;
    end else begin
      adjAcc = accIn + SDB_FIX_BOTH;
      adjCy = 1'b1;
      adjAc = 1'b1;
    end
  end
endmodule : sdb_bcd_unit

// *** logic/sdb_bit_alu.sv ***
// Shift, digit rotate, decimal adjust and single-bit unit with bus slave
`timescale 1ns/1ps
module sdb_bit_alu import sdb_pkg::*; #(
  parameter int WORD_W = 16,
  parameter int CNT_W = 3
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy
);
  // ==========================================================
  // Elaboration check
  if (WORD_W != 16 || CNT_W != 3) begin : g_badParam
    $error("sdb_bit_alu supports only a 16-bit word and 3-bit count");
  end

  // ==========================================================
  // Storage
  logic ackR; // Bus answer
  logic [31:0] datOR; // Read data
  logic [15:0] ctrlR; // Command word
  logic [WORD_W-1:0] dataR; // Shift operand
  logic [7:0] accR; // Accumulator
  logic [7:0] memR; // Memory byte
  logic [7:0] pswR; // Status word with flags
  logic [7:0] saddrR; // Short direct byte
  logic [7:0] sfrR; // Special function byte
  logic [7:0] xR; // X register
  logic [CNT_W-1:0] cntR; // Steps left
  sdb_state_t stateR; // Sequencer

  // ==========================================================
  // Bus decode
  logic access; // New request this edge
  logic wrOk; // Write accepted
  logic startP; // Command launch
  logic [31:0] wrMask; // Lane mask
  logic [31:0] ctrlIn; // Merged command
  logic [15:0] cmd; // Command in force

  assign access = wb_cyc_i & wb_stb_i & ~ackR;
  // Writes only land while idle so a running shift is never disturbed
  assign wrOk = access & wb_we_i & (stateR == SDB_IDLE);
  assign startP = wrOk & (wb_adr_i == SDB_CTRL_OFS) & wb_sel_i[0];

  // Byte lane expansion
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wrMask[8*i+:8] = {8{wb_sel_i[i]}};
  end

  assign ctrlIn = ({16'h0000, ctrlR} & ~wrMask) | (wb_dat_i & wrMask);
  // Launch edge uses the new word, steps use the held one
  assign cmd = startP ? ctrlIn[15:0] : ctrlR;

  // ==========================================================
  // Command fields
  sdb_op_t op;
  sdb_sel_t sel;
  logic [CNT_W-1:0] cnt;
  logic [2:0] bitIdx;
  logic negate;
  logic toBit;

  assign op = sdb_op_t'(cmd[SDB_OP_LSB+:4]);
  assign cnt = cmd[SDB_CNT_LSB+:CNT_W];
  assign bitIdx = cmd[SDB_BIT_LSB+:3];
  assign negate = cmd[SDB_NEG_BIT];
  assign sel = sdb_sel_t'(cmd[SDB_SEL_LSB+:3]);
  assign toBit = cmd[SDB_DIR_BIT];

  // Operation classes
  logic isShift;
  logic isWord;
  logic isRight;
  assign isShift = (op == SDB_OP_SHR) || (op == SDB_OP_SHL) ||
                   (op == SDB_OP_WORD_LOGICAL_RIGHT_SHIFT) || (op == SDB_OP_WORD_LOGICAL_LEFT_SHIFT);
  assign isWord = (op == SDB_OP_WORD_LOGICAL_RIGHT_SHIFT) || (op == SDB_OP_WORD_LOGICAL_LEFT_SHIFT);
  assign isRight = (op == SDB_OP_SHR) || (op == SDB_OP_WORD_LOGICAL_RIGHT_SHIFT);

  // Sequencer events
  logic stepP; // One shift step this edge
  logic lastP; // Final step this edge
  assign stepP = (stateR == SDB_STEP);
  assign lastP = stepP && (cntR == CNT_W'(1));

  // ==========================================================
  // One shift step
  logic [WORD_W-1:0] stepData;
  logic stepOut;
  logic stepZero;

  always_comb begin
    stepData = dataR;
    stepOut = 1'b0;
    case (op)
      SDB_OP_SHR: begin
        stepData = {dataR[15:8], 1'b0, dataR[7:1]};
        stepOut = dataR[0];
      end
      SDB_OP_SHL: begin
        stepData = {dataR[15:8], dataR[6:0], 1'b0};
        stepOut = dataR[7];
      end
      SDB_OP_WORD_LOGICAL_RIGHT_SHIFT: begin
        stepData = {1'b0, dataR[15:1]};
        stepOut = dataR[0];
      end
      SDB_OP_WORD_LOGICAL_LEFT_SHIFT: begin
        stepData = {dataR[14:0], 1'b0};
        stepOut = dataR[15];
      end
      default: begin
        stepData = dataR;
        stepOut = 1'b0;
      end
    endcase
  end

  // Byte shifts judge zero on the low byte only
  assign stepZero = isWord ? (stepData == '0) : (stepData[7:0] == 8'h00);

  // ==========================================================
  // Bit operand selection
  logic [7:0] srcByte;
  logic srcBit;
  logic cyNow;

  always_comb begin
    case (sel)
      SDB_SEL_SADDR: srcByte = saddrR;
      SDB_SEL_SFR: srcByte = sfrR;
      SDB_SEL_ACC: srcByte = accR;
      SDB_SEL_X: srcByte = xR;
      SDB_SEL_PSW: srcByte = pswR;
      default: srcByte = 8'h00;
    endcase
  end

  assign srcBit = srcByte[bitIdx];
  assign cyNow = pswR[SDB_PSW_CY];

  // Bit command qualifiers
  logic bitMove;
  logic bitToCy;
  logic bitFromCy;
  logic bitAnd;
  assign bitMove = startP && (op == SDB_OP_MOVB);
  assign bitToCy = bitMove && !toBit;
  assign bitFromCy = bitMove && toBit;
  assign bitAnd = startP && (op == SDB_OP_ANDB);

  // ==========================================================
  // Decimal and digit datapath
  logic [7:0] adjAcc;
  logic adjCy;
  logic adjAc;
  logic [7:0] rorAcc;
  logic [7:0] rorMem;
  logic [7:0] rolAcc;
  logic [7:0] rolMem;

  sdb_bcd_unit u_bcd (
    .accIn(accR),
    .memIn(memR),
    .cyIn(pswR[SDB_PSW_CY]),
    .acIn(pswR[SDB_PSW_AC]),
    .subSel(op == SDB_OP_ADJS),
    .adjAcc(adjAcc),
    .adjCy(adjCy),
    .adjAc(adjAc),
    .rorAcc(rorAcc),
    .rorMem(rorMem),
    .rolAcc(rolAcc),
    .rolMem(rolMem)
  );

  // ==========================================================
  // Bus answer and read data
  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ackR <= 1'b0;
    end else begin
      ackR <= access;
    end
  end

  // Read mux registered; unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      datOR <= 32'h0000_0000;
    end else if (access) begin
      case (wb_adr_i)
        SDB_CTRL_OFS: datOR <= {(stateR != SDB_IDLE), 15'h0000, ctrlR};
        SDB_DATA_OFS: datOR <= {16'h0000, dataR};
        SDB_ACC_OFS: datOR <= {24'h00_0000, accR};
        SDB_MEM_OFS: datOR <= {24'h00_0000, memR};
        SDB_PSW_OFS: datOR <= {24'h00_0000, pswR};
        SDB_SADDR_OFS: datOR <= {24'h00_0000, saddrR};
        SDB_SFR_OFS: datOR <= {24'h00_0000, sfrR};
        SDB_XREG_OFS: datOR <= {24'h00_0000, xR};
        default: datOR <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ackR;
  assign wb_dat_o = datOR;
  assign busy = (stateR != SDB_IDLE);

  // ==========================================================
  // Command register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlR <= SDB_CTRL_RST;
    end else if (wrOk && wb_adr_i == SDB_CTRL_OFS) begin
      ctrlR <= ctrlIn[15:0];
    end
  end

  // ==========================================================
  // Shift sequencer: one position per cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stateR <= SDB_IDLE;
      cntR <= SDB_CNT_RST;
    end else begin
      case (stateR)
        SDB_IDLE: begin
          // Zero count never leaves idle
          if (startP && isShift && cnt != '0) begin
            stateR <= SDB_STEP;
            cntR <= cnt;
          end
        end
        SDB_STEP: begin
          cntR <= cntR - CNT_W'(1);
          if (cntR == CNT_W'(1)) begin
            stateR <= SDB_IDLE;
          end
        end
        default: begin
          stateR <= SDB_IDLE;
          cntR <= SDB_CNT_RST;
        end
      endcase
    end
  end

  // ==========================================================
  // Shift operand
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataR <= SDB_DATA_RST;
    end else if (stepP) begin
      dataR <= stepData;
    end else if (wrOk && wb_adr_i == SDB_DATA_OFS) begin
      dataR <= (dataR & ~wrMask[15:0]) | (wb_dat_i[15:0] & wrMask[15:0]);
    end
  end

  // ==========================================================
  // Accumulator and memory byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      accR <= SDB_BYTE_RST;
    end else if (startP && op == SDB_OP_NIBBLE_ROTATE_RIGHT) begin
      accR <= rorAcc;
    end else if (startP && op == SDB_OP_NIBBLE_ROTATE_LEFT) begin
      accR <= rolAcc;
    end else if (startP && (op == SDB_OP_ADJA || op == SDB_OP_ADJS)) begin
      accR <= adjAcc;
    end else if (bitFromCy && sel == SDB_SEL_ACC) begin
      accR[bitIdx] <= cyNow;
    end else if (wrOk && wb_adr_i == SDB_ACC_OFS && wb_sel_i[0]) begin
      accR <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      memR <= SDB_BYTE_RST;
    end else if (startP && op == SDB_OP_NIBBLE_ROTATE_RIGHT) begin
      memR <= rorMem;
    end else if (startP && op == SDB_OP_NIBBLE_ROTATE_LEFT) begin
      memR <= rolMem;
    end else if (wrOk && wb_adr_i == SDB_MEM_OFS && wb_sel_i[0]) begin
      memR <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Plain bit targets
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      saddrR <= SDB_BYTE_RST;
      sfrR <= SDB_BYTE_RST;
      xR <= SDB_BYTE_RST;
    end else if (bitFromCy) begin
      // Carry copied out to the chosen bit
      case (sel)
        SDB_SEL_SADDR: saddrR[bitIdx] <= cyNow;
        SDB_SEL_SFR: sfrR[bitIdx] <= cyNow;
        SDB_SEL_X: xR[bitIdx] <= cyNow;
        default: xR <= xR;
      endcase
    end else if (wrOk && wb_sel_i[0]) begin
      if (wb_adr_i == SDB_SADDR_OFS) begin
        saddrR <= wb_dat_i[7:0];
      end
      if (wb_adr_i == SDB_SFR_OFS) begin
        sfrR <= wb_dat_i[7:0];
      end
      if (wb_adr_i == SDB_XREG_OFS) begin
        xR <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // Status word and flags
  // Rotations and non-flag bit writes fall through untouched
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pswR <= SDB_BYTE_RST;
    end else if (lastP) begin
      pswR[SDB_PSW_Z] <= stepZero;
      pswR[SDB_PSW_AC] <= 1'b0;
      pswR[SDB_PSW_CY] <= stepOut;
    end else if (startP && (op == SDB_OP_ADJA || op == SDB_OP_ADJS)) begin
      pswR[SDB_PSW_Z] <= (adjAcc == 8'h00);
      pswR[SDB_PSW_AC] <= adjAc;
      pswR[SDB_PSW_CY] <= adjCy;
    end else if (bitToCy) begin
      pswR[SDB_PSW_CY] <= srcBit;
    end else if (bitFromCy && sel == SDB_SEL_PSW) begin
      pswR[bitIdx] <= cyNow;
    end else if (bitAnd) begin
      pswR[SDB_PSW_CY] <= cyNow & (srcBit ^ negate);
    end else if (wrOk && wb_adr_i == SDB_PSW_OFS && wb_sel_i[0]) begin
      pswR <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Checks
  a_count_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startP && isShift && cnt == '0) |=> $stable(pswR) && $stable(dataR)
    && stateR == SDB_IDLE)
    else $error("zero count changed state");

  a_shift_ac: assert property (@(posedge sys_clk) disable iff (!rstn)
    lastP |=> !pswR[SDB_PSW_AC])
    else $error("half-carry not cleared by shift");

  a_shift_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lastP && isWord) |=> pswR[SDB_PSW_Z] == (dataR == '0))
    else $error("zero flag wrong after word shift");

  a_shr_fill: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stepP && op == SDB_OP_SHR) |=> !dataR[7])
    else $error("byte right shift filled a one");

  a_word_logical_right_shift_fill: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stepP && op == SDB_OP_WORD_LOGICAL_RIGHT_SHIFT) |=> !dataR[15])
    else $error("word right shift filled a one");

  a_left_fill: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stepP && !isRight) |=> !dataR[0])
    else $error("left shift filled a one");

  a_right_carry: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lastP && isRight) |=> pswR[SDB_PSW_CY] == $past(dataR[0]))
    else $error("right shift carry wrong");

  a_left_carry: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lastP && op == SDB_OP_WORD_LOGICAL_LEFT_SHIFT) |=> pswR[SDB_PSW_CY] == $past(dataR[15]))
    else $error("word left shift carry wrong");

  a_step_count: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startP && isShift && cnt == CNT_W'(3)) |=> stepP [*3] ##1 !stepP)
    else $error("shift step count wrong");

  a_rot_upper: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startP && (op == SDB_OP_NIBBLE_ROTATE_RIGHT || op == SDB_OP_NIBBLE_ROTATE_LEFT))
    |=> accR[7:4] == $past(accR[7:4]) && $stable(pswR))
    else $error("digit rotation disturbed accumulator or flags");

  a_adj_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startP && (op == SDB_OP_ADJA || op == SDB_OP_ADJS))
    |=> pswR[SDB_PSW_Z] == (accR == 8'h00))
    else $error("zero flag wrong after decimal adjust");

  a_bit_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
    (bitFromCy && sel != SDB_SEL_PSW) |=> $stable(pswR))
    else $error("plain bit write touched flags");
endmodule : sdb_bit_alu

// *** tb/sdb_seq_model.sv ***
// Bus master model standing in for the instruction sequencer
`timescale 1ns/1ps
module sdb_seq_model (
  input wire logic sys_clk,
  output logic wbCyc,
  output logic wbStb,
  output logic wbWe,
  output logic [7:0] wbAdr,
  output logic [3:0] wbSel,
  output logic [31:0] wbDatW,
  input wire logic wbAck,
  input wire logic [31:0] wbDatR,
  output int tmoCnt
);
  // Bus idle at time zero
  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    tmoCnt = 0;
  end
  // One classic cycle, held until ack is sampled high; bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatW <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    if (wbAck !== 1'b1) tmoCnt++;
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : xfer
endmodule : sdb_seq_model

// *** tb/test_shift_digit_bcd_bit_alu.sv ***
// Self-checking bench of the shift, digit, BCD and bit unit
`timescale 1ns/1ps
module test_shift_digit_bcd_bit_alu import sdb_pkg::*;;
  logic sys_clk, rstn, wbCyc, wbStb, wbWe, wbAck, busy;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR;
  int tmoCnt, errTotal = 0, checkCount = 0;
  sdb_bit_alu dut_u (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .busy(busy));
  sdb_seq_model bus_u (.sys_clk(sys_clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbAck(wbAck), .wbDatR(wbDatR),
    .tmoCnt(tmoCnt));
  // ==========
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic closeOut();
    $display("checks=%0d errors=%0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : closeOut
  // Any bus timeout is fatal for the run
  task automatic xact(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    bus_u.xfer(w, a, d, q);
    if (tmoCnt != 0) begin
      errTotal++;
      closeOut();
    end
  endtask : xact
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xact(1'b1, a, d, q);
  endtask : wr
  task automatic want(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xact(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : want
  // Launch a command, wait for stepping to end under a bound
  task automatic run(input logic [15:0] c, input logic poke);
    int n;
    wr(SDB_CTRL_OFS, {16'h0, c});
    // Long shift: busy seen on the pin and in the command word mid-run
    if (poke) begin
      want(SDB_CTRL_OFS, {1'b1, 15'h0, c});
      check({31'h0, busy}, 32'h1);
      wr(SDB_DATA_OFS, 32'hFFFF);
    end
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (busy !== 1'b0) begin
      errTotal++;
      closeOut();
    end
  endtask : run
  // ==========
  // Scenarios
  task automatic testReset();
    want(SDB_DATA_OFS, 32'h0);
    want(SDB_PSW_OFS, 32'h0);
    want(SDB_CTRL_OFS, 32'h0);
    check({31'h0, busy}, 32'h0);
    wr(8'h20, 32'hFF);
    want(8'h20, 32'h0);
  endtask : testReset
  // All four shifts, counts 0/1/3/7, a write poked in while busy is refused
  task automatic testShift();
    int cs[4] = '{0, 1, 3, 7};
    logic [15:0] d, e;
    logic c, z;
    for (int op = 1; op <= 4; op++) begin
      for (int k = 0; k < 8; k++) begin
        d = k[0] ? 16'h35AC : 16'h8001;
        wr(SDB_DATA_OFS, {16'h0, d});
        wr(SDB_PSW_OFS, 32'h51);
        e = d;
        c = 1'b0;
        for (int s = 0; s < cs[k/2]; s++) begin
          if (op == 1) begin c = e[0]; e[7:0] = {1'b0, e[7:1]}; end
          else if (op == 3) begin c = e[0]; e = {1'b0, e[15:1]}; end
          else if (op == 2) begin c = e[7]; e[7:0] = {e[6:0], 1'b0}; end
          else begin c = e[15]; e = {e[14:0], 1'b0}; end
        end
        z = (op < 3) ? (e[7:0] == 8'h00) : (e == 16'h0);
        run({9'h0, 3'(cs[k/2]), 4'(op)}, cs[k/2] == 7);
        want(SDB_DATA_OFS, {16'h0, e});
        want(SDB_PSW_OFS, (cs[k/2] == 0) ? 32'h51 : {25'h0, z, 5'h0, c});
      end
    end
  endtask : testShift
  task automatic testDigit();
    for (int r = 0; r < 2; r++) begin
      wr(SDB_ACC_OFS, 32'hA7);
      wr(SDB_MEM_OFS, 32'h3C);
      wr(SDB_PSW_OFS, 32'h51);
      run(r ? 16'h0006 : 16'h0005, 1'b0);
      want(SDB_ACC_OFS, r ? 32'hA3 : 32'hAC);
      want(SDB_MEM_OFS, r ? 32'hC7 : 32'h73);
      want(SDB_PSW_OFS, 32'h51);
    end
  endtask : testDigit
  // Decimal correction worked out from the condition tables
  task automatic testAdjust();
    logic [7:0] av[7] = '{8'h99, 8'h9A, 8'h8B, 8'hA5, 8'h00, 8'h66, 8'h3C};
    logic [7:0] a;
    logic c, h;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 28; i++) begin
        a = av[i/4];
        wr(SDB_ACC_OFS, {24'h0, a});
        wr(SDB_PSW_OFS, {27'h0, i[1], 3'h0, i[0]});
        if (s == 1) begin c = i[0]; h = i[1]; end
        else if (!i[1] && a[3:0] <= 4'h9) begin c = !(a[7:4] <= 4'h9 && !i[0]); h = 1'b0; end
        else if (!i[1]) begin c = !(a[7:4] < 4'h9 && !i[0]); h = 1'b1; end
        else begin c = !(a[7:4] <= 4'h9 && !i[0]); h = 1'b1; end
        a = s ? a - {c ? 4'h6 : 4'h0, h ? 4'h6 : 4'h0} : a + {c ? 4'h6 : 4'h0, h ? 4'h6 : 4'h0};
        run(s ? 16'h0008 : 16'h0007, 1'b0);
        want(SDB_ACC_OFS, {24'h0, a});
        want(SDB_PSW_OFS, {25'h0, a == 8'h00, 1'b0, h, 3'h0, c});
      end
    end
  endtask : testAdjust
  // Every operand source, every bit of the plain sources and bits 0/2/6 of the status word, move both ways and product plain and negated
  task automatic testBit();
    logic [7:0] adrs[5] = '{SDB_SADDR_OFS, SDB_SFR_OFS, SDB_ACC_OFS, SDB_XREG_OFS, SDB_PSW_OFS};
    logic [7:0] v, p, ve, pe;
    logic [2:0] b;
    for (int s = 0; s < 5; s++) begin
      for (int i = 0; i < 32; i++) begin
        p = i[2] ? 8'h51 : 8'h40;
        b = (s == 4) ? 3'((i / 4) % 3 * 2 + ((i / 4) % 3 == 2 ? 2 : 0)) : 3'(i / 4);
        v = (s == 4) ? p : 8'h5A;
        wr(adrs[s], {24'h0, v});
        wr(SDB_PSW_OFS, {24'h0, p});
        ve = v;
        pe = p;
        if (i % 4 == 0) pe[0] = v[b];
        else if (i % 4 == 1) ve[b] = p[0];
        else pe[0] = p[0] & (v[b] ^ i[0]);
        if (s == 4 && i % 4 == 1) pe = ve;
        else if (s == 4) ve = pe;
        run({i % 4 == 1, 3'(s), i % 4 == 3, b, 4'h0, (i % 4 < 2) ? 4'h9 : 4'hA}, 1'b0);
        want(adrs[s], {24'h0, ve});
        want(SDB_PSW_OFS, {24'h0, pe});
      end
    end
  endtask : testBit
  // ==========
  // Clock, reset and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    testReset();
    testShift();
    testDigit();
    testAdjust();
    testBit();
    closeOut();
  end
endmodule : test_shift_digit_bcd_bit_alu
